// File: hw/rmsi_monitor.sv
/*
 * Reference monitor: validation timers, live status, interrupt snapshot,
 * event masks and interrupt request, reached over APB.
 * Assumes live conditions synchronous to ref_clk and an lfTick pulse per
 * loop filter clock period.
 */
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
// Summary of operation
// - After a loss or out-of-limits fault, wait the validation time before use.
// - Validation time is loop clock period times two to (code plus one), minus one.
// - Both status registers are read-only and always show live conditions.
// - Estimator failure sets bit 6 when frequency too high, bit 5 when too low.
// - Bit 4 is set once the frequency estimator succeeded.
// - Bit 3 shows the active reference: 0 first, 1 second.
// - Bit 2 is set while the loop is in holdover.
// - Bit 1 reports phase lock; ignore it in single tone and holdover.
// - Bit 0 reports frequency lock; phase lock without it is allowed.
// - Second status: first reference at 6..4, second at 2..0; 7, 3 reserved.
// - On interrupt both status registers are captured into the snapshots.
// - Snapshot bits clear only on interrupt reset, control bit 5.
// - Mask bit 2 raises an interrupt when the active reference changes.
// - Mask bit 1 interrupts on leaving holdover, bit 0 on entering it.
// - Further mask bits interrupt on edges of lock, valid, loss, out-of-limits.
module rmsi_monitor (
    input  wire logic                 ref_clk,
    input  wire logic                 arst_n,
    input  wire logic                 ce,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [13:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire rmsi_pkg::rmsi_live_t live,
    input  wire logic                 lfTick,
    output logic      [1:0]           refValid,
    output logic                      irq
);

    ////////////////////////////////////////////////////////////////////////

    rmsi_pkg::rmsi_state_t cur_ff;
    rmsi_pkg::rmsi_state_t nxt_cur;
    logic [11:0]           idx;
    logic                  setupRd;
    logic                  wrAcc;
    logic                  rdAcc;
    logic                  irqRst;
    logic [7:0]            st0;
    logic [7:0]            st1;
    logic [31:0]           edgesEv;
    logic [31:0]           evNew;
    logic                  hit;
    logic [31:0]           rdVal;

    function automatic logic [5:0] ref_edges(input logic [2:0] was, input logic [2:0] now);
        // Triple order valid, loss, out-of-limits; rise then fall for each
        ref_edges = {now[2] & ~was[2], ~now[2] & was[2],
                     now[1] & ~was[1], ~now[1] & was[1],
                     now[0] & ~was[0], ~now[0] & was[0]};
    endfunction

    function automatic logic is_mapped(input logic [11:0] i);
        is_mapped = (i == rmsi_pkg::IDX_CTRL)  || (i == rmsi_pkg::IDX_VALTIMER) ||
                    (i == rmsi_pkg::IDX_STAT0) || (i == rmsi_pkg::IDX_STAT1) ||
                    (i == rmsi_pkg::IDX_SNAP0) || (i == rmsi_pkg::IDX_SNAP1) ||
                    (i == rmsi_pkg::IDX_MASK0) || (i == rmsi_pkg::IDX_MASK1) ||
                    (i == rmsi_pkg::IDX_MASK2) || (i == rmsi_pkg::IDX_MASK3) ||
                    (i == rmsi_pkg::IDX_EVENTS);
    endfunction

    ////////////////////////////////////////////////////////////////////////

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_val
            rmsi_ref_validator u_val (
                .ref_clk (ref_clk),
                .arst_n  (arst_n),
                .ce      (ce),
                .lfTick  (lfTick),
                .fault   (live.lossOfRef[g] | live.outOfLimits[g]),
                .code    (cur_ff.valTimer),
                .valid   (refValid[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////

    assign idx     = paddr[13:2];
    assign setupRd = psel & ~penable;
    assign wrAcc   = ce & psel & penable & pwrite;
    assign rdAcc   = ce & psel & penable & ~pwrite;
    assign irqRst  = wrAcc && (idx == rmsi_pkg::IDX_CTRL) && pwdata[rmsi_pkg::CTRL_IRQ_RESET_BIT];
    assign hit     = is_mapped(idx);

    // Status is rebuilt from live inputs every cycle, never latched
    assign st0 = rmsi_pkg::rmsi_stat0(live);
    assign st1 = rmsi_pkg::rmsi_stat1(live, refValid);

    always_comb begin
        edgesEv = 32'h0;
        edgesEv[rmsi_pkg::EV_ENTER_HO]  = st0[2] & ~cur_ff.prev0[2];
        edgesEv[rmsi_pkg::EV_LEAVE_HO]  = ~st0[2] & cur_ff.prev0[2];
        edgesEv[rmsi_pkg::EV_REF_CHG]   = st0[3] ^ cur_ff.prev0[3];
        edgesEv[rmsi_pkg::EV_FR_LOCK]   = st0[0] & ~cur_ff.prev0[0];
        edgesEv[rmsi_pkg::EV_FR_UNLOCK] = ~st0[0] & cur_ff.prev0[0];
        edgesEv[rmsi_pkg::EV_PH_LOCK]   = st0[1] & ~cur_ff.prev0[1];
        edgesEv[rmsi_pkg::EV_PH_UNLOCK] = ~st0[1] & cur_ff.prev0[1];
        edgesEv[rmsi_pkg::EV_EST_DONE]  = st0[4] & ~cur_ff.prev0[4];
        edgesEv[rmsi_pkg::EV_REF_BASE0 +: 6] = ref_edges(cur_ff.prev1[6:4], st1[6:4]);
        edgesEv[rmsi_pkg::EV_REF_BASE1 +: 6] = ref_edges(cur_ff.prev1[2:0], st1[2:0]);
    end

    assign evNew = edgesEv & cur_ff.mask;

    always_comb begin
        unique case (1'b1)
            idx == rmsi_pkg::IDX_VALTIMER: rdVal = {27'h0, cur_ff.valTimer};
            idx == rmsi_pkg::IDX_STAT0:    rdVal = {24'h0, st0};
            idx == rmsi_pkg::IDX_STAT1:    rdVal = {24'h0, st1};
            idx == rmsi_pkg::IDX_SNAP0:    rdVal = {24'h0, cur_ff.snap0};
            idx == rmsi_pkg::IDX_SNAP1:    rdVal = {24'h0, cur_ff.snap1};
            idx == rmsi_pkg::IDX_MASK0:    rdVal = {24'h0, cur_ff.mask[7:0]};
            idx == rmsi_pkg::IDX_MASK1:    rdVal = {24'h0, cur_ff.mask[15:8]};
            idx == rmsi_pkg::IDX_MASK2:    rdVal = {24'h0, cur_ff.mask[23:16]};
            idx == rmsi_pkg::IDX_MASK3:    rdVal = {24'h0, cur_ff.mask[31:24]};
            // Edge of the setup cycle is reported, else the clear at access drops it
            idx == rmsi_pkg::IDX_EVENTS:   rdVal = cur_ff.events | edgesEv;
            default:                       rdVal = 32'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        nxt_cur       = cur_ff;
        nxt_cur.prev0 = st0;
        nxt_cur.prev1 = st1;

        // Read data is latched in setup so it stands stable through access
        if (setupRd) begin
            nxt_cur.prdata  = pwrite ? 32'h0 : rdVal;
            nxt_cur.pslverr = ~hit;
        end

        if (wrAcc) begin
            unique case (1'b1)
                idx == rmsi_pkg::IDX_VALTIMER: nxt_cur.valTimer = pwdata[4:0];
                idx == rmsi_pkg::IDX_MASK0: nxt_cur.mask[7:0]   = pwdata[7:0] & rmsi_pkg::MASK_USED[7:0];
                idx == rmsi_pkg::IDX_MASK1: nxt_cur.mask[15:8]  = pwdata[7:0] & rmsi_pkg::MASK_USED[15:8];
                idx == rmsi_pkg::IDX_MASK2: nxt_cur.mask[23:16] = pwdata[7:0] & rmsi_pkg::MASK_USED[23:16];
                idx == rmsi_pkg::IDX_MASK3: nxt_cur.mask[31:24] = pwdata[7:0] & rmsi_pkg::MASK_USED[31:24];
                default: nxt_cur.valTimer = cur_ff.valTimer;
            endcase
        end

        // Event log: read clears, a new edge in the same cycle wins
        if (rdAcc && idx == rmsi_pkg::IDX_EVENTS) begin
            nxt_cur.events = 32'h0;
        end
        nxt_cur.events = nxt_cur.events | edgesEv;

        if (irqRst) begin
            nxt_cur.irq   = 1'b0;
            nxt_cur.snap0 = 8'h00;
            nxt_cur.snap1 = 8'h00;
        end
        // A fresh event beats a reset in the same cycle
        if (|evNew) begin
            nxt_cur.irq = 1'b1;
            if (!cur_ff.irq || irqRst) begin
                nxt_cur.snap0 = st0;
                nxt_cur.snap1 = st1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cur_ff <= '{valTimer: rmsi_pkg::VALTIMER_RST, mask: rmsi_pkg::MASK_RST,
                        default: '0};
        end else if (ce) begin
            cur_ff <= nxt_cur;
        end
    end

    // Zero wait states; a frozen block holds the master off
    assign pready  = ce;
    assign prdata  = cur_ff.prdata;
    assign pslverr = cur_ff.pslverr & psel & penable;
    assign irq     = cur_ff.irq;

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_evt_seen;
        ce && (|evNew);
    endsequence

    sequence s_clean_rst;
        ce && irqRst && !(|evNew);
    endsequence

    a_irq_hold: assert property (cur_ff.irq && !irqRst |=> irq)
        else $error("interrupt dropped without reset");

    a_irq_raise: assert property (s_evt_seen |=> irq ##0 cur_ff.irq)
        else $error("unmasked event did not raise interrupt");

    a_ref_change: assert property (ce && cur_ff.mask[2] && (live.refSecond != cur_ff.prev0[3]) |=> irq)
        else $error("reference change did not interrupt");

    a_holdover_enter: assert property (ce && cur_ff.mask[0] && live.holdover && !cur_ff.prev0[2] |=> irq)
        else $error("holdover entry did not interrupt");

    a_snap_capture: assert property (s_evt_seen ##0 !cur_ff.irq |=> cur_ff.snap0 == $past(st0)
                                     && cur_ff.snap1 == $past(st1))
        else $error("snapshot not captured at interrupt");

    a_snap_clear: assert property (s_clean_rst |=> !irq && cur_ff.snap0 == 8'h00 && cur_ff.snap1 == 8'h00)
        else $error("interrupt reset did not clear snapshot");

    a_stat_live: assert property (ce && setupRd && !pwrite && idx == rmsi_pkg::IDX_STAT0
                                  |=> prdata[7:0] == $past(st0) && prdata[31:8] == 24'h0)
        else $error("status read not live");

    a_stat1_map: assert property (ce && setupRd && !pwrite && idx == rmsi_pkg::IDX_STAT1
                                  |=> prdata[6] == $past(refValid[0]) && prdata[2] == $past(refValid[1])
                                  && !prdata[7] && !prdata[3])
        else $error("second status layout wrong");

    a_timer_write: assert property (wrAcc && idx == rmsi_pkg::IDX_VALTIMER
                                    |=> cur_ff.valTimer == $past(pwdata[4:0]))
        else $error("validation timer write lost");

endmodule // rmsi_monitor

// File: hw/rmsi_pkg.sv
/*
 * Package of the reference monitor: register indices, field positions,
 * reset values, carrier and state types, shared helper functions.
 * Assumes an APB slave with 32-bit data, one register per aligned word.
 */
package rmsi_pkg;

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_CTRL     = 12'h012;
    localparam logic [11:0] IDX_VALTIMER = 12'h1c3;
    localparam logic [11:0] IDX_STAT0    = 12'h300;
    localparam logic [11:0] IDX_STAT1    = 12'h301;
    localparam logic [11:0] IDX_SNAP0    = 12'h302;
    localparam logic [11:0] IDX_SNAP1    = 12'h303;
    localparam logic [11:0] IDX_MASK0    = 12'h304;
    localparam logic [11:0] IDX_MASK1    = 12'h305;
    localparam logic [11:0] IDX_MASK2    = 12'h306;
    localparam logic [11:0] IDX_MASK3    = 12'h307;
    localparam logic [11:0] IDX_EVENTS   = 12'h340;

    localparam int          CTRL_IRQ_RESET_BIT = 5;
    localparam logic [4:0]  VALTIMER_RST       = 5'h00;
    localparam logic [31:0] MASK_RST           = 32'h0000_0000;
    localparam logic [31:0] MASK_USED          = 32'h3f3f_1f07;

    // Event positions, same layout as the four mask bytes
    localparam int EV_ENTER_HO  = 0;
    localparam int EV_LEAVE_HO  = 1;
    localparam int EV_REF_CHG   = 2;
    localparam int EV_FR_LOCK   = 8;
    localparam int EV_FR_UNLOCK = 9;
    localparam int EV_PH_LOCK   = 10;
    localparam int EV_PH_UNLOCK = 11;
    localparam int EV_EST_DONE  = 12;
    localparam int EV_REF_BASE0 = 16;
    localparam int EV_REF_BASE1 = 24;

    // Live condition inputs; index 0 is the first reference, 1 the second
    typedef struct packed {
        logic       freqTooHigh;
        logic       freqTooLow;
        logic       estDone;
        logic       refSecond;
        logic       holdover;
        logic       phaseLock;
        logic       freqLock;
        logic [1:0] lossOfRef;
        logic [1:0] outOfLimits;
    } rmsi_live_t;

    typedef enum logic [1:0] {
        RV_WAIT  = 2'b01,
        RV_VALID = 2'b10
    } rmsi_rv_state_t;

    typedef struct packed {
        rmsi_rv_state_t st;
        logic [32:0]    cnt;
    } rmsi_rv_t;

    typedef struct packed {
        logic [4:0]  valTimer;
        logic [31:0] mask;
        logic [31:0] events;
        logic [7:0]  snap0;
        logic [7:0]  snap1;
        logic        irq;
        logic [7:0]  prev0;
        logic [7:0]  prev1;
        logic [31:0] prdata;
        logic        pslverr;
    } rmsi_state_t;

    // Loop filter ticks needed to validate: 2^(code+1) - 1
    function automatic logic [32:0] rmsi_term(input logic [4:0] code);
        rmsi_term = (33'h1 << ({1'b0, code} + 6'h1)) - 33'h1;
    endfunction

    function automatic logic [7:0] rmsi_stat0(input rmsi_live_t lv);
        rmsi_stat0 = {1'b0, lv.freqTooHigh, lv.freqTooLow, lv.estDone,
                      lv.refSecond, lv.holdover, lv.phaseLock, lv.freqLock};
    endfunction

    function automatic logic [7:0] rmsi_stat1(input rmsi_live_t lv, input logic [1:0] vld);
        rmsi_stat1 = {1'b0, vld[0], lv.lossOfRef[0], lv.outOfLimits[0],
                      1'b0, vld[1], lv.lossOfRef[1], lv.outOfLimits[1]};
    endfunction

endpackage

// File: hw/rmsi_ref_validator.sv
/*
 * Validation timer for one reference input.
 * Assumes lfTick is a one-cycle pulse per loop filter clock period.
 */
`timescale 1ns/1ps
module rmsi_ref_validator (
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    input  wire logic       lfTick,
    input  wire logic       fault,
    input  wire logic [4:0] code,
    output logic            valid
);

    rmsi_pkg::rmsi_rv_t cur_ff;
    rmsi_pkg::rmsi_rv_t nxt_cur;
    logic [32:0]        term;

    assign term = rmsi_pkg::rmsi_term(code);

    always_comb begin
        nxt_cur = cur_ff;
        unique case (cur_ff.st)
            rmsi_pkg::RV_WAIT: begin
                if (fault) begin
                    nxt_cur.cnt = 33'h0;
                end else if (lfTick) begin
                    nxt_cur.cnt = cur_ff.cnt + 33'h1;
                    // Compare with >= so a shorter code written mid-count cannot stall
                    if (cur_ff.cnt + 33'h1 >= term) begin
                        nxt_cur.st = rmsi_pkg::RV_VALID;
                    end
                end
            end
            rmsi_pkg::RV_VALID: begin
                if (fault) begin
                    nxt_cur.st  = rmsi_pkg::RV_WAIT;
                    nxt_cur.cnt = 33'h0;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cur_ff <= '{st: rmsi_pkg::RV_WAIT, cnt: 33'h0};
        end else if (ce) begin
            cur_ff <= nxt_cur;
        end
    end

    assign valid = (cur_ff.st == rmsi_pkg::RV_VALID);

    a_fault_drop: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ce && fault |=> !valid)
        else $error("reference stayed valid after a fault");

    a_valid_wait: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(valid) |-> $past(lfTick) && ($past(cur_ff.cnt) + 33'h1 >= $past(term)))
        else $error("reference validated before its time");

endmodule // rmsi_ref_validator

// File: tb/rmsi_monitor_tb.sv
/*
 * Self-checking bench of the reference monitor: APB register access,
 * validation timing, live status, event log, snapshots and interrupt.
 * Assumes the design files under hw/ are compiled before this one.
 */
`timescale 1ns/1ps
module rmsi_monitor_tb;
    logic                 ref_clk;
    logic                 arst_n;
    logic                 ce;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [13:0]          paddr;
    logic [31:0]          pwdata;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    rmsi_pkg::rmsi_live_t live;
    logic                 lfTick;
    logic [1:0]           refValid;
    logic                 irq;
    int                   fails;
    int                   nChecks;
    logic [31:0]          seed;
    logic [31:0]          rd;
    logic [31:0]          r;
    logic                 err;
    logic [10:0]          v;
    logic [11:0]          mIdx;
    // Event position, live bit that causes it, level before the edge
    int evId  [16] = '{0, 1, 2, 8, 9, 10, 11, 12, 19, 18, 17, 16, 27, 26, 25, 24};
    int evBit [16] = '{6, 6, 7, 4, 4, 5, 5, 8, 2, 2, 0, 0, 3, 3, 1, 1};
    int evSt  [16] = '{0, 1, 0, 0, 1, 0, 1, 0, 0, 1, 0, 1, 0, 1, 0, 1};
    logic [11:0] rstIdx [9] = '{rmsi_pkg::IDX_CTRL, rmsi_pkg::IDX_VALTIMER, rmsi_pkg::IDX_SNAP0,
                                rmsi_pkg::IDX_SNAP1, rmsi_pkg::IDX_MASK0, rmsi_pkg::IDX_MASK1,
                                rmsi_pkg::IDX_MASK2, rmsi_pkg::IDX_MASK3, rmsi_pkg::IDX_EVENTS};

    rmsi_monitor i_rmsi_monitor (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .ce       (ce),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .prdata   (prdata),
        .pready   (pready),
        .pslverr  (pslverr),
        .live     (live),
        .lfTick   (lfTick),
        .refValid (refValid),
        .irq      (irq)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] st0(input logic [10:0] x);
        return {25'h0, x[10:4]};
    endfunction

    function automatic logic [31:0] st1(input logic [10:0] x, input logic [1:0] vl);
        return {24'h0, 1'b0, vl[0], x[2], x[0], 1'b0, vl[1], x[3], x[1]};
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Request held until pready is sampled high; data taken at that edge
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        // No wait-state count assumed; the watchdog ends a hang
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic setLive(input logic [10:0] x);
        @(posedge ref_clk);
        live <= rmsi_pkg::rmsi_live_t'(x);
    endtask

    task automatic tick();
        @(posedge ref_clk);
        lfTick <= 1'b1;
        @(posedge ref_clk);
        lfTick <= 1'b0;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Whole run is about a thousand cycles; this leaves ample margin
    initial begin
        repeat (30000) @(posedge ref_clk);
        fails++;
        complete_run();
    end

    initial begin
        seed = 32'hd2a7;
        fails = 0;
        nChecks = 0;
        arst_n = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 14'h0000;
        pwdata = 32'h0000_0000;
        live = '0;
        lfTick = 1'b0;
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        waitc(2);
        chk("irq after reset", {31'h0, irq}, 32'h0);
        foreach (rstIdx[i]) begin
            apb(1'b0, rstIdx[i], 32'h0);
            chk("reset value", rd, 32'h0);
        end
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, rmsi_pkg::IDX_STAT0, 32'hffff_ffff);
        apb(1'b0, rmsi_pkg::IDX_STAT0, 32'h0);
        chk("status write ignored", rd, 32'h0);
        chk("mapped no error", {31'h0, err}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            mIdx = rmsi_pkg::IDX_MASK0 + 12'(i);
            apb(1'b1, mIdx, r);
            apb(1'b0, mIdx, 32'h0);
            chk("mask readback", rd, r & {24'h0, rmsi_pkg::MASK_USED[8*i +: 8]});
            apb(1'b1, mIdx, 32'h0);
        end
        r = rnd();
        apb(1'b1, rmsi_pkg::IDX_VALTIMER, r);
        apb(1'b0, rmsi_pkg::IDX_VALTIMER, 32'h0);
        chk("timer readback", rd, r & 32'h1f);
        ////////////////////////////////////////////////////////////////////////
        // Second reference held out of limits so only the first validates
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, rmsi_pkg::IDX_VALTIMER, 32'(c));
            setLive(11'h006);
            waitc(2);
            chk("valid cleared", {30'h0, refValid}, 32'h0);
            setLive(11'h002);
            repeat ((1 << (c + 1)) - 2) tick();
            waitc(1);
            chk("valid early", {30'h0, refValid}, 32'h0);
            tick();
            waitc(1);
            chk("valid on time", {30'h0, refValid}, 32'h1);
            apb(1'b0, rmsi_pkg::IDX_STAT1, 32'h0);
            chk("status1 valid", rd, st1(11'h002, 2'b01));
        end
        apb(1'b0, rmsi_pkg::IDX_EVENTS, 32'h0);
        chk("valid rise event", {31'h0, rd[rmsi_pkg::EV_REF_BASE0 + 5]}, 32'h1);
        setLive(11'h00f);
        waitc(2);
        chk("valid dropped", {30'h0, refValid}, 32'h0);
        // No ticks from here on, so validity stays low
        for (int k = 0; k < 10; k++) begin
            v = (k == 0) ? 11'h7ff : 11'(rnd());
            setLive(v);
            waitc(2);
            apb(1'b0, rmsi_pkg::IDX_STAT0, 32'h0);
            chk("status0", rd, st0(v));
            apb(1'b0, rmsi_pkg::IDX_STAT1, 32'h0);
            chk("status1", rd, st1(v, 2'b00));
        end
        ////////////////////////////////////////////////////////////////////////
        foreach (evId[k]) begin
            v = '0;
            v[evBit[k]] = evSt[k][0];
            setLive(v);
            waitc(3);
            apb(1'b1, rmsi_pkg::IDX_CTRL, 32'h20);
            apb(1'b0, rmsi_pkg::IDX_EVENTS, 32'h0);
            mIdx = rmsi_pkg::IDX_MASK0 + 12'(evId[k] / 8);
            apb(1'b1, mIdx, 32'h1 << (evId[k] % 8));
            v[evBit[k]] = ~v[evBit[k]];
            setLive(v);
            waitc(3);
            chk("irq raised", {31'h0, irq}, 32'h1);
            apb(1'b0, rmsi_pkg::IDX_EVENTS, 32'h0);
            chk("event log", rd, 32'h1 << evId[k]);
            // Later change must not overwrite the held snapshot
            setLive(v ^ 11'h400);
            waitc(2);
            apb(1'b0, rmsi_pkg::IDX_SNAP0, 32'h0);
            chk("snapshot low", rd, st0(v));
            apb(1'b0, rmsi_pkg::IDX_SNAP1, 32'h0);
            chk("snapshot high", rd, st1(v, 2'b00));
            chk("irq held", {31'h0, irq}, 32'h1);
            apb(1'b1, rmsi_pkg::IDX_CTRL, 32'h20);
            waitc(1);
            chk("irq cleared", {31'h0, irq}, 32'h0);
            apb(1'b0, rmsi_pkg::IDX_SNAP0, 32'h0);
            chk("snapshot cleared", rd, 32'h0);
            apb(1'b1, mIdx, 32'h0);
            setLive(v ^ 11'h400 ^ (11'h1 << evBit[k]));
            waitc(3);
            chk("masked event", {31'h0, irq}, 32'h0);
        end
        // Frozen block must neither see nor flag an edge until ce returns
        apb(1'b1, rmsi_pkg::IDX_MASK0, 32'h1);
        ce <= 1'b0;
        setLive(11'h442);
        waitc(3);
        chk("frozen irq", {31'h0, irq}, 32'h0);
        ce <= 1'b1;
        waitc(2);
        chk("thawed irq", {31'h0, irq}, 32'h1);
        complete_run();
    end
endmodule // rmsi_monitor_tb
